// ---- hdl/classifier_next_lookup_ctrl.sv ----
/*
  next-step action handling of a classification match: pipeline point,
  forced key layout, frame pointer advance, plus an apb register slave.
  assumes action fields arrive from same-clock logic with action_valid.
*/
// What this block does
// - forced pipeline point applied only when enabled
// - next key kind zero keeps default selection
// - kinds one to sixteen map fixed layouts
// - kind five picks triple vlan key variant
// - kind eight substitutes destination mac and address
// - kind seventeen completes and disables remaining lookups
// - advance pointer by word offset, four bytes
// - advance pointer by halfword offset, two bytes
// - skipped labels moved automatically, not in offsets
// - layer move first, then fixed offset added
// - layer-skip selector, zero none, three reserved
// - skip code one skips link layer
// - skip code two skips link and ip
// - skip code two on control word skips ip
// - ipv4 skip includes header options
// - two-bit layer type encoding
module classifier_next_lookup_ctrl
  import next_lookup_pkg::*;
#(
  parameter int PTR_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // action from lookup
  input wire logic action_valid,
  input wire logic [1:0] lookup_idx,
  input wire logic pipeline_force_enable,
  input wire logic [POINT_W-1:0] forced_pipeline_point,
  input wire logic [KIND_W-1:0] next_key_kind,
  input wire logic [WORD_ADV_W-1:0] word_pointer_advance,
  input wire logic [HALF_ADV_W-1:0] halfword_pointer_advance,
  input wire logic [SKIP_SEL_W-1:0] layer_skip_select,
  // parse state
  input wire logic frame_start,
  input wire logic [PTR_W-1:0] frame_ptr_in,
  input wire logic [LAYER_W-1:0] layer_type,
  input wire logic [1:0] skipped_labels,
  input wire logic [1:0] vlan_count,
  input wire logic [3:0] ip_version,
  input wire logic [3:0] ipv4_hdr_words,
  // to next key generator
  output logic step_valid,
  output logic point_apply,
  output logic [POINT_W-1:0] point_out,
  output logic analysis_finished,
  output logic key_override,
  output key_layout_t key_layout,
  output logic source_mac_key_field_dst,
  output logic ipv4_source_key_field_dst,
  output logic lookups_complete,
  output logic lookups_disabled,
  output logic [PTR_W-1:0] frame_ptr_out
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [CHOICE_W-1:0] ctrl_r;
  logic [CHOICE_W-1:0] ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [KIND_W-1:0] last_kind_r;
  logic [KIND_W-1:0] last_kind_nxt;
  logic addr_hit;

  always_comb begin
    addr_hit = (paddr == REG_CTRL_ADDR) || (paddr == REG_STATUS_ADDR) || (paddr == REG_COUNT_ADDR);
    ctrl_nxt = ctrl_r;
    if (psel && penable && pwrite && paddr == REG_CTRL_ADDR) begin
      ctrl_nxt = pwdata[CHOICE_W-1:0];
    end
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      case (paddr)
        REG_CTRL_ADDR: prdata_nxt = {{(32-CHOICE_W){1'b0}}, ctrl_r};
        REG_STATUS_ADDR: prdata_nxt = {26'h0, lookups_disabled, last_kind_r};
        REG_COUNT_ADDR: prdata_nxt = {{(32-COUNT_W){1'b0}}, count_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    count_nxt = action_valid ? COUNT_W'(count_r + 1'b1) : count_r;
    last_kind_nxt = action_valid ? next_key_kind : last_kind_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET[CHOICE_W-1:0];
      prdata_r <= 32'h0000_0000;
      count_r <= '0;
      last_kind_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      count_r <= count_nxt;
      last_kind_r <= last_kind_nxt;
    end
  end

  assign pready = psel & penable;
  assign prdata = prdata_r;
  assign pslverr = psel & penable & ~addr_hit;

  // ---------------------------------------------------------------
  // pointer arithmetic
  // ---------------------------------------------------------------
  logic [PTR_W-1:0] skip_bytes;
  logic skip_taken;
  logic [PTR_W-1:0] base_ptr;
  logic [PTR_W-1:0] layer_ptr;
  logic [PTR_W-1:0] fixed_bytes;

  layer_skip_len #(
    .LEN_W(PTR_W)
  ) u_skip (
    .skip_sel(layer_skip_select),
    .layer_type(layer_type),
    .vlan_count(vlan_count),
    .ip_version(ip_version),
    .ipv4_hdr_words(ipv4_hdr_words),
    .skip_bytes(skip_bytes),
    .skip_taken(skip_taken)
  );

  always_comb begin
    base_ptr = PTR_W'(frame_ptr_in + LABEL_BYTES * int'(skipped_labels));
    layer_ptr = PTR_W'(base_ptr + skip_bytes);
    fixed_bytes = PTR_W'(WORD_BYTES * int'(word_pointer_advance)
      + HALF_BYTES * int'(halfword_pointer_advance));
  end

  // ---------------------------------------------------------------
  // action decode
  // ---------------------------------------------------------------
  logic valid_r, valid_nxt;
  logic apply_r, apply_nxt;
  logic [POINT_W-1:0] point_r, point_nxt;
  logic override_r, override_nxt;
  key_layout_t layout_r, layout_nxt;
  logic dst_r, dst_nxt;
  logic done_r, done_nxt;
  logic disabled_r, disabled_nxt;
  logic [PTR_W-1:0] ptr_r, ptr_nxt;

  always_comb begin
    valid_nxt = action_valid;
    apply_nxt = apply_r;
    point_nxt = point_r;
    override_nxt = override_r;
    layout_nxt = layout_r;
    dst_nxt = dst_r;
    done_nxt = 1'b0;
    ptr_nxt = ptr_r;
    disabled_nxt = frame_start ? 1'b0 : disabled_r;
    if (action_valid) begin
      apply_nxt = pipeline_force_enable;
      point_nxt = pipeline_force_enable ? forced_pipeline_point : POINT_NONE;
      override_nxt = (next_key_kind != KIND_DEFAULT) && (next_key_kind <= KIND_LAST_LAYOUT);
      dst_nxt = (next_key_kind == KIND_STANDARD_DST);
      ptr_nxt = PTR_W'(layer_ptr + fixed_bytes);
      case (next_key_kind)
        5'h01: layout_nxt = KL_LABEL_LINK;
        5'h02: layout_nxt = KL_SINGLE_LABEL;
        5'h03: layout_nxt = KL_DOUBLE_LABEL;
        5'h04: layout_nxt = KL_TRIPLE_LABEL;
        KIND_TRIPLE_VLAN: layout_nxt = ctrl_r[lookup_idx] ? KL_TRIPLE_VLAN_ID_INDEX : KL_TRIPLE_VLAN_ID;
        5'h06: layout_nxt = KL_LINK_FULL;
        5'h07: layout_nxt = KL_STANDARD;
        KIND_STANDARD_DST: layout_nxt = KL_STANDARD_DST;
        5'h09: layout_nxt = KL_SEVEN_TUPLE;
        5'h0A: layout_nxt = KL_STD_FIVE_TUPLE;
        5'h0B: layout_nxt = KL_PURE_FIVE_TUPLE;
        5'h0C: layout_nxt = KL_CUSTOM_A;
        5'h0D: layout_nxt = KL_CUSTOM_B;
        5'h0E: layout_nxt = KL_CUSTOM_C;
        5'h0F: layout_nxt = KL_DOUBLE_VID_INDEX;
        KIND_LAST_LAYOUT: layout_nxt = KL_TAG;
        KIND_LOOKUPS_COMPLETE: begin
          layout_nxt = KL_DEFAULT;
          done_nxt = 1'b1;
          disabled_nxt = 1'b1;
        end
        default: layout_nxt = KL_DEFAULT;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      apply_r <= 1'b0;
      point_r <= POINT_NONE;
      override_r <= 1'b0;
      layout_r <= KL_DEFAULT;
      dst_r <= 1'b0;
      done_r <= 1'b0;
      disabled_r <= 1'b0;
      ptr_r <= '0;
    end else begin
      valid_r <= valid_nxt;
      apply_r <= apply_nxt;
      point_r <= point_nxt;
      override_r <= override_nxt;
      layout_r <= layout_nxt;
      dst_r <= dst_nxt;
      done_r <= done_nxt;
      disabled_r <= disabled_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  assign step_valid = valid_r;
  assign point_apply = apply_r;
  assign point_out = point_r;
  assign analysis_finished = apply_r && (point_r == ANALYSIS_FINISHED_POINT);
  assign key_override = override_r;
  assign key_layout = layout_r;
  assign source_mac_key_field_dst = dst_r;
  assign ipv4_source_key_field_dst = dst_r;
  assign lookups_complete = done_r;
  assign lookups_disabled = disabled_r;
  assign frame_ptr_out = ptr_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_point_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && !pipeline_force_enable |=> !point_apply && point_out == POINT_NONE)
    else $error("pipeline point applied without enable");
  a_point_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && pipeline_force_enable |=> point_apply && point_out == $past(forced_pipeline_point))
    else $error("forced pipeline point not applied");
  a_default_key: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && next_key_kind == KIND_DEFAULT |=> !key_override && key_layout == KL_DEFAULT)
    else $error("default key selection overruled");
  a_layout_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && next_key_kind == 5'h0C |=> key_override && key_layout == KL_CUSTOM_A)
    else $error("key layout mapping wrong");
  a_triple_choice: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && next_key_kind == KIND_TRIPLE_VLAN |=>
      key_layout == ($past(ctrl_r[lookup_idx]) ? KL_TRIPLE_VLAN_ID_INDEX : KL_TRIPLE_VLAN_ID))
    else $error("triple vlan key choice wrong");
  a_dst_subst: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid |=> source_mac_key_field_dst == ($past(next_key_kind) == KIND_STANDARD_DST))
    else $error("destination substitution wrong");
  a_done_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && next_key_kind == KIND_LOOKUPS_COMPLETE |=> lookups_complete && lookups_disabled
      ##1 (lookups_disabled || $past(frame_start)))
    else $error("lookups not disabled after completion");
  a_fixed_advance: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && layer_skip_select == SKIP_NONE |=> frame_ptr_out == PTR_W'($past(frame_ptr_in)
      + 4 * $past(skipped_labels) + 4 * $past(word_pointer_advance) + 2 * $past(halfword_pointer_advance)))
    else $error("fixed pointer advance wrong");
  a_reserved_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && (layer_skip_select == RESERVED_CODE || layer_type == RAW_DATA_LAYER) |=>
      frame_ptr_out == PTR_W'($past(frame_ptr_in) + 4 * $past(skipped_labels)
      + 4 * $past(word_pointer_advance) + 2 * $past(halfword_pointer_advance)))
    else $error("reserved skip moved pointer");
  a_link_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && layer_skip_select == SKIP_LINK_LAYER && layer_type == LINK_LAYER_TYPE |=>
      frame_ptr_out == PTR_W'($past(frame_ptr_in) + 4 * $past(skipped_labels) + 12 + 4 * $past(vlan_count)
      + 4 * $past(word_pointer_advance) + 2 * $past(halfword_pointer_advance)))
    else $error("link layer skip wrong");
  a_ipv4_options: assert property (@(posedge sys_clk) disable iff (!rst_n)
    action_valid && layer_skip_select == SKIP_NETWORK_AND_LINK_LAYERS && layer_type == CONTROL_WORD_LAYER
      && ip_version == IP_VERSION_4 |=> frame_ptr_out == PTR_W'($past(frame_ptr_in) + 4 * $past(skipped_labels)
      + 4 * $past(ipv4_hdr_words) + 4 * $past(word_pointer_advance) + 2 * $past(halfword_pointer_advance)))
    else $error("ipv4 header skip wrong");
  a_apb_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psel && !penable ##1 psel && penable |-> pready && prdata == $past(prdata_nxt))
    else $error("apb access answer wrong");
  a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psel && !penable && !pwrite && paddr == REG_CTRL_ADDR ##1 psel && penable |->
      !pslverr && prdata == {{(32-CHOICE_W){1'b0}}, $past(ctrl_r)})
    else $error("control register read back wrong");
endmodule : classifier_next_lookup_ctrl

// ---- hdl/layer_skip_len.sv ----
/*
  combinational length of the protocol layers skipped by a layer-skip code.
  assumes parse fields are stable and on the core clock.
*/
module layer_skip_len
  import next_lookup_pkg::*;
#(
  parameter int LEN_W = 8
) (
  // selection
  input wire logic [1:0] skip_sel,
  input wire logic [1:0] layer_type,
  // parse state
  input wire logic [1:0] vlan_count,
  input wire logic [3:0] ip_version,
  input wire logic [3:0] ipv4_hdr_words,
  // result
  output logic [LEN_W-1:0] skip_bytes,
  output logic skip_taken
);
  // ---------------------------------------------------------------
  // layer lengths
  // ---------------------------------------------------------------
  logic [LEN_W-1:0] link_len;
  logic [LEN_W-1:0] ip_len;
  logic ip_known;

  always_comb begin
    link_len = LEN_W'(MAC_PAIR_BYTES + VLAN_TAG_BYTES * int'(vlan_count));
    ip_known = (ip_version == IP_VERSION_4) || (ip_version == IP_VERSION_6);
    if (ip_version == IP_VERSION_4) begin
      ip_len = LEN_W'(IPV4_WORD_BYTES * int'(ipv4_hdr_words));
    end else begin
      ip_len = LEN_W'(IPV6_HDR_BYTES);
    end
    skip_bytes = '0;
    skip_taken = 1'b0;
    case (skip_sel)
      SKIP_LINK_LAYER: begin
        if (layer_type == LINK_LAYER_TYPE) begin
          skip_bytes = link_len;
          skip_taken = 1'b1;
        end
      end
      SKIP_NETWORK_AND_LINK_LAYERS: begin
        if (layer_type == LINK_LAYER_TYPE && ip_known) begin
          skip_bytes = LEN_W'(link_len + ip_len);
          skip_taken = 1'b1;
        end else if (layer_type == CONTROL_WORD_LAYER && ip_known) begin
          skip_bytes = ip_len;
          skip_taken = 1'b1;
        end
      end
      default: begin
        skip_bytes = '0;
        skip_taken = 1'b0;
      end
    endcase
  end
endmodule : layer_skip_len

// ---- hdl/next_lookup_pkg.sv ----
/*
  constants, codes and types shared by the next-lookup control block.
  assumes a single core clock domain; no other dependencies.
*/
package next_lookup_pkg;
  // ---------------------------------------------------------------
  // action field widths
  // ---------------------------------------------------------------
  localparam int POINT_W = 5;
  localparam int KIND_W = 5;
  localparam int WORD_ADV_W = 2;
  localparam int HALF_ADV_W = 5;
  localparam int SKIP_SEL_W = 2;
  localparam int LAYER_W = 2;

  // ---------------------------------------------------------------
  // pipeline point codes
  // ---------------------------------------------------------------
  localparam logic [4:0] POINT_NONE = 5'h00;
  localparam logic [4:0] ANALYSIS_FINISHED_POINT = 5'h10;

  // ---------------------------------------------------------------
  // next key kind codes
  // ---------------------------------------------------------------
  localparam logic [4:0] KIND_DEFAULT = 5'h00;
  localparam logic [4:0] KIND_TRIPLE_VLAN = 5'h05;
  localparam logic [4:0] KIND_STANDARD_DST = 5'h08;
  localparam logic [4:0] KIND_LAST_LAYOUT = 5'h10;
  localparam logic [4:0] KIND_LOOKUPS_COMPLETE = 5'h11;

  // ---------------------------------------------------------------
  // layer types and layer-skip codes
  // ---------------------------------------------------------------
  localparam logic [1:0] LINK_LAYER_TYPE = 2'h0;
  localparam logic [1:0] CONTROL_WORD_LAYER = 2'h1;
  localparam logic [1:0] LABEL_LAYER = 2'h2;
  localparam logic [1:0] RAW_DATA_LAYER = 2'h3;
  localparam logic [1:0] SKIP_NONE = 2'h0;
  localparam logic [1:0] SKIP_LINK_LAYER = 2'h1;
  localparam logic [1:0] SKIP_NETWORK_AND_LINK_LAYERS = 2'h2;
  localparam logic [1:0] RESERVED_CODE = 2'h3;
  localparam logic [3:0] IP_VERSION_4 = 4'h4;
  localparam logic [3:0] IP_VERSION_6 = 4'h6;

  // ---------------------------------------------------------------
  // byte sizes used for pointer moves
  // ---------------------------------------------------------------
  localparam int MAC_PAIR_BYTES = 12;
  localparam int VLAN_TAG_BYTES = 4;
  localparam int IPV6_HDR_BYTES = 40;
  localparam int IPV4_WORD_BYTES = 4;
  localparam int WORD_BYTES = 4;
  localparam int HALF_BYTES = 2;
  localparam int LABEL_BYTES = 4;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL_ADDR = 12'h000;
  localparam logic [11:0] REG_STATUS_ADDR = 12'h004;
  localparam logic [11:0] REG_COUNT_ADDR = 12'h008;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CHOICE_W = 4;
  localparam int COUNT_W = 16;

  // ---------------------------------------------------------------
  // key layouts
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    KL_DEFAULT,
    KL_LABEL_LINK,
    KL_SINGLE_LABEL,
    KL_DOUBLE_LABEL,
    KL_TRIPLE_LABEL,
    KL_TRIPLE_VLAN_ID,
    KL_TRIPLE_VLAN_ID_INDEX,
    KL_LINK_FULL,
    KL_STANDARD,
    KL_STANDARD_DST,
    KL_SEVEN_TUPLE,
    KL_STD_FIVE_TUPLE,
    KL_PURE_FIVE_TUPLE,
    KL_CUSTOM_A,
    KL_CUSTOM_B,
    KL_CUSTOM_C,
    KL_DOUBLE_VID_INDEX,
    KL_TAG
  } key_layout_t;
endpackage : next_lookup_pkg

// ---- verif/lookup_source_model.sv ----
/*
  behavioural lookup source: hands the block one whole action per request.
  assumes requests are raised by the bench just after a rising edge.
*/
module lookup_source_model
  import next_lookup_pkg::*;
(
  // clock and request
  input wire logic sys_clk,
  input wire logic rq,
  input wire logic [21:0] rf,
  // action to the block
  output logic action_valid,
  output logic [1:0] lookup_idx,
  output logic pipeline_force_enable,
  output logic [POINT_W-1:0] forced_pipeline_point,
  output logic [KIND_W-1:0] next_key_kind,
  output logic [WORD_ADV_W-1:0] word_pointer_advance,
  output logic [HALF_ADV_W-1:0] halfword_pointer_advance,
  output logic [SKIP_SEL_W-1:0] layer_skip_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // action register
  // ---------------------------------------------------------------
  logic valid_r = 1'b0;
  logic [21:0] act_r = '0;
  logic [21:0] act_nxt;
  // idle fields flip each cycle, never look valid
  always_comb begin
    act_nxt = rq ? rf : ~act_r;
  end
  always @(posedge sys_clk) begin
    valid_r <= rq;
    act_r <= act_nxt;
  end
  assign action_valid = valid_r;
  assign {lookup_idx, pipeline_force_enable, forced_pipeline_point, next_key_kind,
          word_pointer_advance, halfword_pointer_advance, layer_skip_select} = act_r;
endmodule : lookup_source_model

// ---- verif/testbench.sv ----
/*
  self-checking bench for the next-lookup control block.
  assumes next_lookup_pkg, the design and lookup_source_model compiled first.
*/
module testbench
  import next_lookup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic pready, pslverr, er;
  logic [31:0] prdata, rd;
  logic rq = 1'b0;
  logic [21:0] rf = '0;
  logic action_valid, pipeline_force_enable;
  logic [1:0] lookup_idx, word_pointer_advance, layer_skip_select;
  logic [4:0] forced_pipeline_point, next_key_kind, halfword_pointer_advance;
  logic frame_start = 1'b0;
  logic [7:0] frame_ptr_in = '0;
  logic [1:0] layer_type = '0, skipped_labels = '0, vlan_count = '0;
  logic [3:0] ip_version = '0, ipv4_hdr_words = '0;
  logic step_valid, point_apply, analysis_finished, key_override;
  logic [4:0] point_out;
  key_layout_t key_layout;
  logic source_mac_key_field_dst, ipv4_source_key_field_dst, lookups_complete, lookups_disabled;
  logic [7:0] frame_ptr_out;
  int err_count = 0, compares = 0, n_act = 0, cyc = 0;

  classifier_next_lookup_ctrl #(.PTR_W(8)) u_classifier_next_lookup_ctrl (.sys_clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .action_valid, .lookup_idx,
    .pipeline_force_enable, .forced_pipeline_point, .next_key_kind, .word_pointer_advance,
    .halfword_pointer_advance, .layer_skip_select, .frame_start, .frame_ptr_in, .layer_type,
    .skipped_labels, .vlan_count, .ip_version, .ipv4_hdr_words, .step_valid, .point_apply, .point_out,
    .analysis_finished, .key_override, .key_layout, .source_mac_key_field_dst,
    .ipv4_source_key_field_dst, .lookups_complete, .lookups_disabled, .frame_ptr_out);
  lookup_source_model u_lookup_source_model (.sys_clk, .rq, .rf, .action_valid, .lookup_idx,
    .pipeline_force_enable, .forced_pipeline_point, .next_key_kind, .word_pointer_advance,
    .halfword_pointer_advance, .layer_skip_select);

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task act(input logic [1:0] ix, input logic en, input logic [4:0] pt, input logic [4:0] k,
           input logic [1:0] w, input logic [4:0] h, input logic [1:0] s);
    @(posedge sys_clk);
    rq <= 1'b1;
    rf <= {ix, en, pt, k, w, h, s};
    @(posedge sys_clk);
    rq <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    n_act++;
    chk(step_valid, 1, "step");
  endtask : act
  function automatic logic [7:0] exp_ptr(input logic [7:0] p, input logic [1:0] s, ly, vl, sk, w,
                                         input logic [3:0] v, ih, input logic [4:0] h);
    int ip;
    int mv;
    ip = (v == 4'h4) ? 4 * ih : (v == 4'h6) ? 40 : -1;
    mv = 0;
    if (s == 2'd1 && ly == 2'd0) mv = 12 + 4 * vl;
    if (s == 2'd2 && ip >= 0 && ly == 2'd0) mv = 12 + 4 * vl + ip;
    if (s == 2'd2 && ip >= 0 && ly == 2'd1) mv = ip;
    return 8'(p + 4 * sk + mv + 4 * w + 2 * h);
  endfunction : exp_ptr
  task pc(input logic [7:0] p, input logic [1:0] s, ly, vl, sk, w, input logic [3:0] v, ih,
          input logic [4:0] h);
    @(posedge sys_clk);
    frame_ptr_in <= p;
    layer_type <= ly;
    vlan_count <= vl;
    skipped_labels <= sk;
    ip_version <= v;
    ipv4_hdr_words <= ih;
    act(2'd0, 1'b0, 5'h00, 5'h00, w, h, s);
    chk(frame_ptr_out, exp_ptr(p, s, ly, vl, sk, w, v, ih, h), "ptr");
  endtask : pc
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_point;
    act(2'd0, 1'b1, ANALYSIS_FINISHED_POINT, 5'h00, 2'd0, 5'h00, 2'd0);
    chk({point_apply, point_out, analysis_finished}, {1'b1, 5'h10, 1'b1}, "pt done");
    act(2'd0, 1'b0, 5'h09, 5'h00, 2'd0, 5'h00, 2'd0);
    chk({point_apply, point_out, analysis_finished}, {1'b0, 5'h00, 1'b0}, "pt off");
    act(2'd0, 1'b1, 5'h09, 5'h00, 2'd0, 5'h00, 2'd0);
    chk({point_apply, point_out, analysis_finished}, {1'b1, 5'h09, 1'b0}, "pt on");
    $display("test point done");
  endtask : t_point
  task t_kinds;
    logic [4:0] kk, e;
    for (int k = 0; k < 19; k++) begin
      kk = (k == 18) ? 5'h14 : 5'(k);
      e = (kk == 0 || kk > 16) ? 5'h00 : (kk <= 5) ? kk : kk + 5'h01;
      act(2'd0, 1'b0, 5'h00, kk, 2'd0, 5'h00, 2'd0);
      chk({key_override, 5'(key_layout)}, {kk >= 1 && kk <= 16, e}, "kind");
      chk({source_mac_key_field_dst, ipv4_source_key_field_dst}, {2{kk == 8}}, "dst");
      chk({lookups_complete, lookups_disabled}, {kk == 17, k >= 17}, "done");
    end
    @(posedge sys_clk);
    frame_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    @(negedge sys_clk);
    chk({step_valid, lookups_complete, lookups_disabled}, 0, "new frame");
    $display("test kinds done");
  endtask : t_kinds
  task t_regs;
    apb(1'b0, REG_CTRL_ADDR, 32'h0);
    chk(rd, CTRL_RESET, "ctrl reset");
    apb(1'b1, REG_CTRL_ADDR, 32'h4);
    apb(1'b0, REG_CTRL_ADDR, 32'h0);
    chk(rd, 32'h4, "ctrl");
    chk(er, 0, "ctrl resp");
    act(2'd2, 1'b0, 5'h00, KIND_TRIPLE_VLAN, 2'd0, 5'h00, 2'd0);
    chk(key_layout, KL_TRIPLE_VLAN_ID_INDEX, "vid idx");
    act(2'd1, 1'b0, 5'h00, KIND_TRIPLE_VLAN, 2'd0, 5'h00, 2'd0);
    chk(key_layout, KL_TRIPLE_VLAN_ID, "vid");
    apb(1'b1, REG_STATUS_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, REG_STATUS_ADDR, 32'h0);
    chk(rd, 32'h5, "status");
    apb(1'b0, REG_COUNT_ADDR, 32'h0);
    chk(rd, n_act, "count");
    apb(1'b0, 12'h00C, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped");
    $display("test regs done");
  endtask : t_regs
  task t_ptr;
    pc(8'h10, 2'd0, 2'd0, 2'd0, 2'd0, 2'd3, 4'h0, 4'h0, 5'h00);
    pc(8'h10, 2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 4'h0, 4'h0, 5'h1F);
    pc(8'h20, 2'd0, 2'd2, 2'd0, 2'd3, 2'd1, 4'h0, 4'h0, 5'h01);
    pc(8'h00, 2'd1, 2'd0, 2'd3, 2'd0, 2'd1, 4'h0, 4'h0, 5'h01);
    pc(8'h00, 2'd2, 2'd0, 2'd1, 2'd0, 2'd0, 4'h4, 4'hF, 5'h00);
    pc(8'h00, 2'd2, 2'd0, 2'd2, 2'd0, 2'd2, 4'h6, 4'h0, 5'h03);
    pc(8'h08, 2'd2, 2'd1, 2'd0, 2'd0, 2'd0, 4'h4, 4'h5, 5'h00);
    pc(8'h08, 2'd2, 2'd1, 2'd3, 2'd1, 2'd0, 4'h6, 4'h0, 5'h00);
    pc(8'h08, 2'd3, 2'd0, 2'd2, 2'd0, 2'd1, 4'h4, 4'h5, 5'h02);
    pc(8'h08, 2'd1, 2'd2, 2'd2, 2'd0, 2'd0, 4'h0, 4'h0, 5'h00);
    pc(8'h08, 2'd2, 2'd3, 2'd1, 2'd0, 2'd0, 4'h4, 4'h5, 5'h00);
    pc(8'h08, 2'd2, 2'd0, 2'd1, 2'd0, 2'd0, 4'h5, 4'h5, 5'h00);
    pc(8'hF0, 2'd2, 2'd1, 2'd0, 2'd3, 2'd3, 4'h4, 4'hF, 5'h1F);
    $display("test pointer done");
  endtask : t_ptr
  // ---------------------------------------------------------------
  // main sequence and timeout
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({step_valid, point_apply, key_override, lookups_disabled, 5'(key_layout), frame_ptr_out}, 32'h0, "reset");
    t_point;
    t_kinds;
    t_regs;
    t_ptr;
    end_sim;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim;
    end
  end
endmodule : testbench
